/* File: mrtro_decode.sv */
// Instruction classifier for the four supported operations
module mrtro_decode
  import mrtro_pkg::*;
(
  input wire logic [15:0] instr,  // Opcode word
  output logic is_move,           // Peripheral to file move
  output logic is_rfi,            // Return from interrupt
  output logic is_rlit,           // Return with literal
  output logic is_tread,          // Program word read
  output logic illegal            // Not one of the above
);

  // Pure pattern match on the upper bits; interrupt return matches the whole word
  always_comb
  begin
    is_move = (instr[15:13] == MRTRO_MOVE_TOP);
    is_rfi = (instr == MRTRO_RFI_CODE);
    is_rlit = (instr[15:8] == MRTRO_RLIT_TOP);
    is_tread = (instr[15:10] == MRTRO_WREAD_TOP);
    illegal = !(is_move || is_rfi || is_rlit || is_tread);
  end

endmodule

/* File: mrtro_exec.sv */
// Executor for move, returns and program word read, with an AXI4-Lite control port
//
// Overview of operation
// [RULE1] Move copies 5-bit peripheral operand into 8-bit file register, updates zero flag.
// [RULE2] Interrupt return pops stack into PC, keeps upper latch, takes two cycles.
// [RULE3] Interrupt return clears global interrupt disable, status bit 4.
// [RULE4] Literal return writes instruction low byte into the working register.
// [RULE5] Literal return pops stack into PC, keeps upper latch, two cycles.
// [RULE6] Word read with select 1 stores high latch, reloads latch, increments if asked.
// [RULE7] Word read with select 0 stores low latch, reloads latch, pointer kept unless asked.
// [RULE8] Second cycle of every return is a no-operation while fetch refills.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
module mrtro_exec
  import mrtro_pkg::*;
(
  input wire logic aclk,                   // Instruction clock
  input wire logic aresetn,                // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr,     // Write address
  input wire logic s_axi_awvalid,          // Write address valid
  output logic s_axi_awready,              // Write address ready
  input wire logic [31:0] s_axi_wdata,     // Write data
  input wire logic [3:0] s_axi_wstrb,      // Write strobes
  input wire logic s_axi_wvalid,           // Write data valid
  output logic s_axi_wready,               // Write data ready
  output logic [1:0] s_axi_bresp,          // Write response
  output logic s_axi_bvalid,               // Write response valid
  input wire logic s_axi_bready,           // Write response ready
  input wire logic [7:0] s_axi_araddr,     // Read address
  input wire logic s_axi_arvalid,          // Read address valid
  output logic s_axi_arready,              // Read address ready
  output logic [31:0] s_axi_rdata,         // Read data
  output logic [1:0] s_axi_rresp,          // Read response
  output logic s_axi_rvalid,               // Read data valid
  input wire logic s_axi_rready,           // Read data ready
  output mrtro_file_req_type file_req,     // Register file access
  input wire logic [7:0] file_rd_data,     // Register file read data
  output mrtro_mem_req_type mem_req,       // Stack pop and program memory read
  input wire logic [15:0] stack_top_entry, // Top of hardware stack
  input wire logic [15:0] pmem_rd_data,    // Program memory word at pointer
  output logic [15:0] pc_out,              // Program counter
  output logic busy                        // Instruction in progress
);

  mrtro_state_type state_reg, state_next;
  logic [15:0] instr_reg, instr_next;
  logic [7:0] working_register_reg, working_register_next;
  logic [7:0] core_status_reg_reg, core_status_reg_next;
  logic [15:0] program_word_pointer_reg, program_word_pointer_next;
  logic [7:0] word_latch_high_reg, word_latch_high_next;
  logic [7:0] word_latch_low_reg, word_latch_low_next;
  logic [15:0] pc_reg, pc_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic is_move, is_rfi, is_rlit, is_tread, illegal;

  // Byte merge under write strobe
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] s, input int lane);
    merge_byte = s[lane] ? d[lane*8 +: 8] : old;
  endfunction

  mrtro_decode u_decode (
    .instr(instr_reg),
    .is_move(is_move),
    .is_rfi(is_rfi),
    .is_rlit(is_rlit),
    .is_tread(is_tread),
    .illegal(illegal)
  );

  // Handshake outputs
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign pc_out = pc_reg;
  assign busy = (state_reg != MRTRO_IDLE);

  // Register bus and instruction execution
  always_comb
  begin
    state_next = state_reg;
    instr_next = instr_reg;
    working_register_next = working_register_reg;
    core_status_reg_next = core_status_reg_reg;
    program_word_pointer_next = program_word_pointer_reg;
    word_latch_high_next = word_latch_high_reg;
    word_latch_low_next = word_latch_low_reg;
    pc_next = pc_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    file_req = '0;
    mem_req = '0;

    // Address and data taken in either order; strobes are held with the data,
    // since the master may change them once the data half is taken
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_next = 1'b0;

    // Commit once both halves are held; instruction writes wait while busy
    if (aw_got_reg && w_got_reg && !bvalid_reg)
    begin
      bresp_next = MRTRO_RESP_OKAY;
      if (awaddr_reg == MRTRO_OFF_INSTR)
      begin
        if (state_reg == MRTRO_IDLE)
        begin
          instr_next = wdata_reg[15:0];
          state_next = MRTRO_EXEC;
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          bvalid_next = 1'b1;
        end
      end
      else
      begin
        aw_got_next = 1'b0;
        w_got_next = 1'b0;
        bvalid_next = 1'b1;
        if (awaddr_reg == MRTRO_OFF_WORK)
          working_register_next = merge_byte(working_register_reg, wdata_reg, wstrb_reg, 0);
        else if (awaddr_reg == MRTRO_OFF_PTR)
          program_word_pointer_next = {merge_byte(program_word_pointer_reg[15:8], wdata_reg,
            wstrb_reg, 1), merge_byte(program_word_pointer_reg[7:0], wdata_reg, wstrb_reg, 0)};
        else if (awaddr_reg == MRTRO_OFF_LATCH)
        begin
          word_latch_high_next = merge_byte(word_latch_high_reg, wdata_reg, wstrb_reg, 1);
          word_latch_low_next = merge_byte(word_latch_low_reg, wdata_reg, wstrb_reg, 0);
        end
        else if (awaddr_reg == MRTRO_OFF_CSTA)
          core_status_reg_next = merge_byte(core_status_reg_reg, wdata_reg, wstrb_reg, 0);
        else
          bresp_next = MRTRO_RESP_SLVERR;
      end
    end

    // Read side, one cycle after the address
    if (s_axi_rvalid && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = MRTRO_RESP_OKAY;
      if (s_axi_araddr == MRTRO_OFF_INSTR)
        rdata_next = {16'h0000, instr_reg};
      else if (s_axi_araddr == MRTRO_OFF_STATUS)
        rdata_next = {21'h0, state_reg, core_status_reg_reg};
      else if (s_axi_araddr == MRTRO_OFF_WORK)
        rdata_next = {24'h000000, working_register_reg};
      else if (s_axi_araddr == MRTRO_OFF_PTR)
        rdata_next = {16'h0000, program_word_pointer_reg};
      else if (s_axi_araddr == MRTRO_OFF_LATCH)
        rdata_next = {16'h0000, word_latch_high_reg, word_latch_low_reg};
      else if (s_axi_araddr == MRTRO_OFF_PC)
        rdata_next = {16'h0000, pc_reg};
      else if (s_axi_araddr == MRTRO_OFF_CSTA)
        rdata_next = {24'h000000, core_status_reg_reg};
      else
      begin
        rdata_next = 32'h00000000;
        rresp_next = MRTRO_RESP_SLVERR;
      end
    end

    // Executor; register file read data is combinational from the address
    case (state_reg)
      MRTRO_IDLE:
      begin
        state_next = state_next;
      end
      MRTRO_EXEC:
      begin
        state_next = MRTRO_IDLE;
        if (is_move)
        begin
          file_req.rd_en = 1'b1; // RULE1
          file_req.rd_addr = {3'h0, instr_reg[12:8]};
          file_req.wr_en = 1'b1;
          file_req.wr_addr = instr_reg[7:0];
          file_req.wr_data = file_rd_data;
          core_status_reg_next[MRTRO_ZERO_BIT] = (file_rd_data == 8'h00); // RULE1
        end
        else if (is_rfi || is_rlit)
        begin
          mem_req.pop = 1'b1;
          pc_next = stack_top_entry; // RULE2 RULE5
          if (is_rfi)
            core_status_reg_next[MRTRO_INTDIS_BIT] = 1'b0; // RULE3
          else
            working_register_next = instr_reg[7:0]; // RULE4
          state_next = MRTRO_NOP2; // RULE2 RULE5
        end
        else if (is_tread)
        begin
          file_req.wr_en = 1'b1;
          file_req.wr_addr = instr_reg[7:0];
          file_req.wr_data = instr_reg[MRTRO_TBL_T_BIT] ? word_latch_high_reg
            : word_latch_low_reg; // RULE6 RULE7
          mem_req.pmem_rd = 1'b1;
          mem_req.pmem_addr = program_word_pointer_reg;
          word_latch_high_next = pmem_rd_data[15:8]; // RULE6 RULE7
          word_latch_low_next = pmem_rd_data[7:0];
          if (instr_reg[MRTRO_TBL_I_BIT])
            program_word_pointer_next = program_word_pointer_reg + 16'h0001; // RULE6
        end
        else if (illegal)
          state_next = MRTRO_IDLE; // Unknown opcode passes as a one-cycle no-op
      end
      MRTRO_NOP2:
        state_next = MRTRO_IDLE; // RULE8
      default:
        state_next = MRTRO_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= MRTRO_IDLE;
      instr_reg <= 16'h0000;
      working_register_reg <= 8'h00;
      core_status_reg_reg <= MRTRO_CSTA_RST;
      program_word_pointer_reg <= MRTRO_PTR_RST;
      word_latch_high_reg <= 8'h00;
      word_latch_low_reg <= 8'h00;
      pc_reg <= 16'h0000;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      working_register_reg <= working_register_next;
      core_status_reg_reg <= core_status_reg_next;
      program_word_pointer_reg <= program_word_pointer_next;
      word_latch_high_reg <= word_latch_high_next;
      word_latch_low_reg <= word_latch_low_next;
      pc_reg <= pc_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

endmodule

/* File: mrtro_exec_props.sv */
// Checker: port timing of the instruction executor
module mrtro_props
  import mrtro_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_bvalid, // Resp valid
  input wire logic s_axi_bready, // Resp ready
  input wire mrtro_file_req_type file_req, // File access
  input wire logic [7:0] file_rd_data, // File data
  input wire mrtro_mem_req_type mem_req, // Pop, word read
  input wire logic [15:0] stack_top_entry, // Stack top
  input wire logic [15:0] pc_out, // PC
  input wire logic busy // Busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Refill cycle carries no request, then the executor is free
  sequence s_refill;
    busy && !mem_req.pop && !mem_req.pmem_rd && !file_req.wr_en && !file_req.rd_en;
  endsequence
  sequence s_back_idle;
    s_refill ##1 !busy;
  endsequence
  a_pop_loads_pc: assert property (mem_req.pop |=> pc_out == $past(stack_top_entry))
    else $error("pc not loaded from stack top");
  a_return_refill: assert property (mem_req.pop |=> s_back_idle)
    else $error("return second cycle not idle");
  a_pc_only_pop: assert property (!mem_req.pop |=> $stable(pc_out))
    else $error("pc moved without a return");
  a_busy_short: assert property ($rose(busy) |-> ##[1:2] !busy)
    else $error("instruction too long");
  a_move_copy: assert property (file_req.rd_en |-> file_req.wr_en &&
    file_req.wr_data == file_rd_data && file_req.rd_addr[7:5] == 3'h0)
    else $error("move data wrong");
  a_tread_write: assert property (mem_req.pmem_rd |-> file_req.wr_en && !mem_req.pop)
    else $error("word read without file write");
  a_req_first: assert property ((mem_req.pop || file_req.wr_en) |-> $rose(busy))
    else $error("request outside execute cycle");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule

bind mrtro_exec mrtro_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .file_req, .file_rd_data, .mem_req, .stack_top_entry, .pc_out, .busy);

/* File: mrtro_partner.sv */
// Core side model: file registers, stack top and program memory
module mrtro_partner
  import mrtro_pkg::*;
(
  input wire logic aclk, // Clock
  input wire mrtro_file_req_type file_req, // File access
  output logic [7:0] file_rd_data, // File data
  input wire mrtro_mem_req_type mem_req, // Pop, word read
  output logic [15:0] stack_top_entry, // Stack top
  output logic [15:0] pmem_rd_data // Program word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rf [256];
  logic [15:0] top;
  logic [15:0] junk = 16'h0;
  // Idle reads show a moving pattern, so a stale sample is caught
  assign file_rd_data = file_req.rd_en ? rf[file_req.rd_addr] : junk[7:0];
  assign pmem_rd_data = mem_req.pmem_rd ?
    {mem_req.pmem_addr[7:0], mem_req.pmem_addr[15:8]} ^ 16'hA55A : junk;
  assign stack_top_entry = top;
  // Writes land at the edge; a pop bares a different entry
  always @(posedge aclk)
  begin
    junk <= junk + 16'h3B1D;
    if (file_req.wr_en)
      rf[file_req.wr_addr] <= file_req.wr_data;
    if (mem_req.pop)
      top <= ~top;
  end
endmodule

/* File: mrtro_pkg.sv */
// Package: encodings, register layouts, bus offsets and structs for the instruction executor
package mrtro_pkg;

  // Instruction patterns (upper bits)
  localparam logic [2:0] MRTRO_MOVE_TOP = 3'h2;         // 010p pppp ffff ffff
  localparam logic [7:0] MRTRO_RLIT_TOP = 8'hB6;        // 1011 0110 kkkk kkkk
  localparam logic [15:0] MRTRO_RFI_CODE = 16'h0005;
  localparam logic [5:0] MRTRO_WREAD_TOP = 6'h2A;       // 1010 10ti ffff ffff
  localparam int MRTRO_TBL_T_BIT = 9;
  localparam int MRTRO_TBL_I_BIT = 8;
  localparam int MRTRO_INTDIS_BIT = 4;
  localparam int MRTRO_ZERO_BIT = 2;

  // AXI4-Lite register map (byte addresses)
  localparam logic [7:0] MRTRO_OFF_INSTR = 8'h00;   // write: instruction to execute
  localparam logic [7:0] MRTRO_OFF_STATUS = 8'h04;  // read: busy, cycle, core status
  localparam logic [7:0] MRTRO_OFF_WORK = 8'h08;    // working register
  localparam logic [7:0] MRTRO_OFF_PTR = 8'h0C;     // program word pointer
  localparam logic [7:0] MRTRO_OFF_LATCH = 8'h10;   // word latch high:low
  localparam logic [7:0] MRTRO_OFF_PC = 8'h14;      // program counter, read only
  localparam logic [7:0] MRTRO_OFF_CSTA = 8'h18;    // core status register
  localparam logic [1:0] MRTRO_RESP_OKAY = 2'h0;
  localparam logic [1:0] MRTRO_RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [7:0] MRTRO_CSTA_RST = 8'h10;    // interrupts disabled after reset
  localparam logic [15:0] MRTRO_PTR_RST = 16'h0000;

  // Executor states, one-hot
  typedef enum logic [2:0] {
    MRTRO_IDLE = 3'b001,
    MRTRO_EXEC = 3'b010,
    MRTRO_NOP2 = 3'b100
  } mrtro_state_type;

  // File register port toward the core register file
  typedef struct packed {
    logic rd_en;
    logic [7:0] rd_addr;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } mrtro_file_req_type;

  // Stack pop and program memory request
  typedef struct packed {
    logic pop;
    logic pmem_rd;
    logic [15:0] pmem_addr;
  } mrtro_mem_req_type;

endpackage

/* File: tb_move_return_table_read_ops.sv */
// Testbench: executor driven over the register bus against a core model
module tb_move_return_table_read_ops
  import mrtro_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  mrtro_file_req_type file_req;
  mrtro_mem_req_type mem_req;
  logic [7:0] file_rd_data;
  logic [15:0] stack_top_entry, pmem_rd_data, pc_out;
  int err_count = 0, check_count = 0;

  mrtro_exec dut (.*);
  mrtro_partner core (.aclk, .file_req, .file_rd_data, .mem_req, .stack_top_entry,
    .pmem_rd_data);

  initial forever #12.5 aclk = ~aclk;

  function automatic logic [15:0] pm(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'hA55A;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang();
    err_count++;
    conclude();
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  // Handshakes are judged at the falling edge so the rising edge never races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w, b;
    @(posedge aclk);
    {aw, w, b} = 3'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 60 && !b; n++)
    begin
      @(negedge aclk);
      aw = aw || s_axi_awready;
      w = w || s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw)
        s_axi_awvalid <= 1'h0;
      if (w)
        s_axi_wvalid <= 1'h0;
      if (b)
        s_axi_bready <= 1'h0;
    end
    if (!b)
      hang();
  endtask

  task automatic rd(input logic [7:0] a);
    bit ar, r;
    @(posedge aclk);
    {ar, r} = 2'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 60 && !r; n++)
    begin
      @(negedge aclk);
      ar = ar || s_axi_arready;
      r = s_axi_rvalid;
      rd_v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar)
        s_axi_arvalid <= 1'h0;
      if (r)
        s_axi_rready <= 1'h0;
    end
    if (!r)
      hang();
  endtask

  // Issue one instruction and wait for the executor to go idle
  task automatic exec(input logic [15:0] op);
    wr(MRTRO_OFF_INSTR, {16'h0, op});
    repeat (20)
    begin
      @(negedge aclk);
      if (busy === 1'h0)
        return;
    end
    hang();
  endtask

  initial
  begin
    logic [15:0] v, op;
    logic [7:0] f, x;
    logic [4:0] q;
    void'($urandom(88));
    for (int i = 0; i < 256; i++)
      core.rf[i] = 8'($urandom);
    core.rf[0] = 8'h00;
    core.top = 16'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(MRTRO_OFF_CSTA);
    chk("status reset", rd_v, {24'h0, MRTRO_CSTA_RST});
    rd(MRTRO_OFF_PTR);
    chk("pointer reset", rd_v, {16'h0, MRTRO_PTR_RST});
    // Moves, the first one moving a zero
    for (int i = 0; i < 6; i++)
    begin
      q = (i == 0) ? 5'h00 : 5'($urandom);
      f = 8'($urandom);
      x = core.rf[{3'h0, q}];
      exec({MRTRO_MOVE_TOP, q, f});
      chk("move dest", {24'h0, core.rf[f]}, {24'h0, x});
      rd(MRTRO_OFF_CSTA);
      chk("zero flag", {31'h0, rd_v[MRTRO_ZERO_BIT]}, {31'h0, x == 8'h00});
    end
    $display("test move done");
    // Both returns, each with interrupts disabled beforehand
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($urandom);
      x = 8'($urandom);
      wr(MRTRO_OFF_CSTA, 32'h10);
      chk("write resp", {30'h0, resp}, {30'h0, MRTRO_RESP_OKAY});
      core.top <= v;
      exec(i[0] ? {MRTRO_RLIT_TOP, x} : MRTRO_RFI_CODE);
      chk("pc port", {16'h0, pc_out}, {16'h0, v});
      rd(MRTRO_OFF_PC);
      chk("read resp", {30'h0, resp}, {30'h0, MRTRO_RESP_OKAY});
      chk("pc", rd_v, {16'h0, v});
      rd(MRTRO_OFF_CSTA);
      chk("status", rd_v, i[0] ? 32'h10 : 32'h00);
      if (i[0])
      begin
        rd(MRTRO_OFF_WORK);
        chk("literal", rd_v, {24'h0, x});
      end
    end
    $display("test returns done");
    // Word reads in all select and step modes; the last wraps the pointer
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 3) ? 16'hFFFF : 16'($urandom);
      op = 16'($urandom);
      f = 8'($urandom);
      wr(MRTRO_OFF_PTR, {16'h0, v});
      wr(MRTRO_OFF_LATCH, {16'h0, op});
      exec({MRTRO_WREAD_TOP, i[1], i[0], f});
      chk("word dest", {24'h0, core.rf[f]}, {24'h0, i[1] ? op[15:8] : op[7:0]});
      rd(MRTRO_OFF_LATCH);
      chk("latch", rd_v, {16'h0, pm(v)});
      rd(MRTRO_OFF_PTR);
      chk("pointer", rd_v, {16'h0, v + 16'(i[0])});
    end
    $display("test word read done");
    // Partial strobe keeps the low pointer byte; an unknown opcode changes nothing
    s_axi_wstrb <= 4'h2;
    wr(MRTRO_OFF_PTR, 32'h0000BEEF);
    s_axi_wstrb <= 4'hF;
    exec(16'hFFFF);
    rd(MRTRO_OFF_PTR);
    chk("strobe pointer", rd_v, 32'h0000BE00);
    $display("test strobe done");
    // Unmapped and read-only places answer with an error
    rd(8'h1C);
    chk("unmapped resp", {30'h0, resp}, {30'h0, MRTRO_RESP_SLVERR});
    chk("unmapped data", rd_v, 32'h0);
    wr(MRTRO_OFF_PC, 32'h1234);
    chk("pc write resp", {30'h0, resp}, {30'h0, MRTRO_RESP_SLVERR});
    $display("test errors done");
    conclude();
  end
endmodule
